// [core/fprc_pkg.sv]
package fprc_pkg;
   // Clock and pacing
   localparam int CLK_PERIOD_NS = 20;
   localparam int SLOW_CYCLE_MS = 786;
   localparam int NORMAL_CYCLE_MS = 3;
   localparam int SLOW_CYCLES = (SLOW_CYCLE_MS * 1000000) / CLK_PERIOD_NS;
   localparam int PANEL_CNT_W = 24;
   localparam int SYNC_TAP_BIT = 13;
   localparam int SLOW_TAP_BIT = 18;

   // Switch bit positions in the synchroniser bundle
   localparam int SW_STOP = 0;
   localparam int SW_RUN = 1;
   localparam int SW_STEP = 2;
   localparam int SW_SLOW = 3;
   localparam int SW_RESET = 4;
   localparam int SW_PROT = 5;
   localparam int SW_UNPROT = 6;
   localparam int SW_COUNT = 7;

   // Register map, byte addresses
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_COUNT = 8'h08;

   // Control fields
   localparam int CTRL_FETCH_GATE = 0;
   localparam logic CTRL_FETCH_GATE_RST = 1'b1;

   // Status fields
   localparam int ST_STOPPED = 0;
   localparam int ST_STEP = 1;
   localparam int ST_READY = 2;
   localparam int ST_SLOW = 3;
   localparam int ST_PROT = 4;
   localparam int ST_BUSRST = 5;
endpackage

// [core/fprc_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module fprc_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] meta_r;
   logic [WIDTH-1:0] sync_r;

   // Meta stage feeds only the second stage
   genvar g;
   generate
      for (g = 0; g < WIDTH; g++) begin : g_bit
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               meta_r[g] <= 1'b0;
               sync_r[g] <= 1'b0;
            end else begin
               meta_r[g] <= async_i[g];
               sync_r[g] <= meta_r[g];
            end
         end
      end
   endgenerate

   assign sync_o = sync_r;
endmodule
`default_nettype wire

// [core/fprc_run_control.sv]
// Behaviour
// [R01] One ready line: low waits, high runs
// [R02] Stop request crosses two panel-clock latch stages
// [R03] Stop flop sets only on sync, strobe, fetch
// [R04] Processor flags every instruction's first machine cycle
// [R05] Set stop flop holds itself after release
// [R06] Stopped state enables other operator switches
// [R07] Stopped: run indication and ready go low
// [R08] Step press sets step flop, raising ready
// [R09] Next first-cycle coincidence clears step flop
// [R10] Each step needs a fresh press
// [R11] Option drops fetch bit from step clear
// [R12] Slow mode paces cycles far slower than normal
// [R13] Gated counter tap sets step flop in slow
// [R14] Slow keeps stepping; deselecting slow halts
// [R15] Reset switch drives bus reset any time
// [R16] Protect blocks writes, unprotect allows them
// [R17] Separate protect and unprotect bus lines
// [R18] Switches synchronised before touching control state
//
// Design decisions made here: the register offsets and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module fprc_run_control #(
   parameter int SLOW_CYCLES = fprc_pkg::SLOW_CYCLES,
   parameter int CNT_W = fprc_pkg::PANEL_CNT_W,
   parameter int SYNC_TAP = fprc_pkg::SYNC_TAP_BIT,
   parameter int SLOW_TAP = fprc_pkg::SLOW_TAP_BIT
) (
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Operator switches, asynchronous
   input wire logic sw_stop_i,
   input wire logic sw_run_i,
   input wire logic sw_step_i,
   input wire logic sw_slow_i,
   input wire logic sw_reset_i,
   input wire logic sw_protect_i,
   input wire logic sw_unprotect_i,
   // Processor status
   input wire logic bus_cycle_sync_i,
   input wire logic status_strobe_i,
   input wire logic fetch_status_bit_i,
   // Panel outputs
   output logic panel_ready_line_o,
   output logic run_ind_o,
   output logic switches_enable_o,
   output logic bus_reset_o,
   output logic protect_o,
   output logic unprotect_o
);
   // Panel counter advances every PANEL_DIV clocks so the slow tap lands near the slow pace
   localparam int PANEL_DIV_RAW = SLOW_CYCLES / (2 ** (SLOW_TAP + 1));
   localparam int PANEL_DIV = (PANEL_DIV_RAW < 1) ? 1 : PANEL_DIV_RAW;
   localparam int DIV_W = $clog2(PANEL_DIV + 1);
   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(PANEL_DIV - 1);

   generate
      if (SLOW_TAP >= CNT_W || SYNC_TAP >= CNT_W || SYNC_TAP < 0) begin : g_bad_tap
         $error("Counter taps must lie inside the panel counter");
      end
      if (SLOW_CYCLES < 2) begin : g_bad_slow
         $error("Slow pace must span more than one cycle");
      end
   endgenerate

   // Switch synchronisation
   logic [fprc_pkg::SW_COUNT-1:0] sw_raw;
   logic [fprc_pkg::SW_COUNT-1:0] sw_sync;

   assign sw_raw[fprc_pkg::SW_STOP] = sw_stop_i;
   assign sw_raw[fprc_pkg::SW_RUN] = sw_run_i;
   assign sw_raw[fprc_pkg::SW_STEP] = sw_step_i;
   assign sw_raw[fprc_pkg::SW_SLOW] = sw_slow_i;
   assign sw_raw[fprc_pkg::SW_RESET] = sw_reset_i;
   assign sw_raw[fprc_pkg::SW_PROT] = sw_protect_i;
   assign sw_raw[fprc_pkg::SW_UNPROT] = sw_unprotect_i;

   fprc_sync #(
      .WIDTH(fprc_pkg::SW_COUNT)
   ) u_sw_sync ( // [R18]
      .clk_i(clk_i),
      .rst_i(rst_i),
      .async_i(sw_raw),
      .sync_o(sw_sync)
   );

   wire stop_req = sw_sync[fprc_pkg::SW_STOP];
   wire run_req = sw_sync[fprc_pkg::SW_RUN];
   wire step_req = sw_sync[fprc_pkg::SW_STEP];
   wire slow_sel = sw_sync[fprc_pkg::SW_SLOW];
   wire reset_req = sw_sync[fprc_pkg::SW_RESET];
   wire prot_req = sw_sync[fprc_pkg::SW_PROT];
   wire unprot_req = sw_sync[fprc_pkg::SW_UNPROT];

   // Free-running panel counter and its taps
   logic [DIV_W-1:0] div_r;
   logic [CNT_W-1:0] panel_cnt_r;
   logic sync_tap_d_r;
   logic slow_tap_d_r;

   wire div_wrap = (div_r == DIV_LAST);
   wire [DIV_W-1:0] div_nxt = div_wrap ? '0 : div_r + DIV_W'(1);
   wire [CNT_W-1:0] panel_cnt_nxt = div_wrap ? panel_cnt_r + CNT_W'(1) : panel_cnt_r;
   wire sync_clock_tap = panel_cnt_r[SYNC_TAP] & ~sync_tap_d_r;
   wire slow_clock_tap = panel_cnt_r[SLOW_TAP] & ~slow_tap_d_r;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         div_r <= '0;
         panel_cnt_r <= '0;
         sync_tap_d_r <= 1'b0;
         slow_tap_d_r <= 1'b0;
      end else begin
         div_r <= div_nxt; // [R12]
         panel_cnt_r <= panel_cnt_nxt;
         sync_tap_d_r <= panel_cnt_r[SYNC_TAP];
         slow_tap_d_r <= panel_cnt_r[SLOW_TAP];
      end
   end

   // Control register
   logic fetch_gate_r;

   // Stop path
   logic stop_stage1_r;
   logic stop_stage2_r;
   logic stop_step_flipflop_r;
   logic step_r;
   logic step_req_d_r;

   // Boundary decode; processor marks each first machine cycle
   wire cycle_mark = bus_cycle_sync_i & status_strobe_i; // [R04]
   wire coincide_full = cycle_mark & fetch_status_bit_i; // [R03]
   wire coincide_step = cycle_mark & (fetch_status_bit_i | ~fetch_gate_r); // [R11]

   wire stop_stage1_nxt = sync_clock_tap ? stop_req : stop_stage1_r;
   wire stop_stage2_nxt = sync_clock_tap ? stop_stage1_r : stop_stage2_r;
   wire stop_set = stop_stage2_r & coincide_full & ~stop_step_flipflop_r;
   wire stop_clr = run_req & stop_step_flipflop_r & ~stop_stage2_r;
   wire stop_nxt = stop_set | (stop_step_flipflop_r & ~stop_clr);

   wire step_edge = step_req & ~step_req_d_r;
   wire slow_start = slow_sel & slow_clock_tap;
   wire step_set = stop_step_flipflop_r & (step_edge | slow_start);
   wire step_clr = step_r & coincide_step;
   wire step_nxt = step_set | (step_r & ~step_clr);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         stop_stage1_r <= 1'b0;
         stop_stage2_r <= 1'b0;
      end else begin
         stop_stage1_r <= stop_stage1_nxt; // [R02]
         stop_stage2_r <= stop_stage2_nxt; // [R02]
      end
   end

   // Set wins over run so a stop in flight is never lost
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         stop_step_flipflop_r <= 1'b0;
      end else begin
         stop_step_flipflop_r <= stop_nxt; // [R03] [R05]
      end
   end

   // A fresh press or a slow tick outranks the boundary clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         step_r <= 1'b0;
         step_req_d_r <= 1'b0;
      end else begin
         step_r <= step_nxt; // [R08] [R09] [R13] [R14]
         step_req_d_r <= step_req; // [R10]
      end
   end

   // Ready and run indication
   wire ready_nxt = ~stop_step_flipflop_r | step_r; // [R01] [R07]
   assign panel_ready_line_o = ready_nxt;
   assign run_ind_o = ~stop_step_flipflop_r; // [R07]
   assign switches_enable_o = stop_step_flipflop_r; // [R06]

   // Reset and protect lines
   logic bus_reset_r;
   logic protect_r;
   logic unprotect_r;
   logic prot_state_r;

   // Protect wins when both positions read at once; lines stay exclusive
   wire prot_drive = stop_step_flipflop_r & prot_req;
   wire unprot_drive = stop_step_flipflop_r & unprot_req & ~prot_req;
   wire prot_state_nxt = prot_drive ? 1'b1 : (unprot_drive ? 1'b0 : prot_state_r);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bus_reset_r <= 1'b0;
         protect_r <= 1'b0;
         unprotect_r <= 1'b0;
         prot_state_r <= 1'b0;
      end else begin
         bus_reset_r <= reset_req; // [R15]
         protect_r <= prot_drive; // [R06] [R16] [R17]
         unprotect_r <= unprot_drive; // [R16] [R17]
         prot_state_r <= prot_state_nxt;
      end
   end

   assign bus_reset_o = bus_reset_r;
   assign protect_o = protect_r;
   assign unprotect_o = unprotect_r;

   // Wishbone slave, one wait-state registered ack
   logic ack_r;
   logic [31:0] rd_data_r;

   wire wb_req = wb_cyc_i & wb_stb_i & ~ack_r;
   wire hit_ctrl = (wb_adr_i == fprc_pkg::REG_CTRL);
   wire hit_status = (wb_adr_i == fprc_pkg::REG_STATUS);
   wire hit_count = (wb_adr_i == fprc_pkg::REG_COUNT);
   wire ctrl_wr = wb_req & wb_we_i & hit_ctrl & wb_sel_i[0];
   wire fetch_gate_nxt = ctrl_wr ? wb_dat_i[fprc_pkg::CTRL_FETCH_GATE] : fetch_gate_r;

   logic [31:0] ctrl_word;
   logic [31:0] status_word;
   logic [31:0] count_word;
   logic [31:0] rd_mux;

   always_comb begin
      ctrl_word = '0;
      ctrl_word[fprc_pkg::CTRL_FETCH_GATE] = fetch_gate_r;
      status_word = '0;
      status_word[fprc_pkg::ST_STOPPED] = stop_step_flipflop_r;
      status_word[fprc_pkg::ST_STEP] = step_r;
      status_word[fprc_pkg::ST_READY] = ready_nxt;
      status_word[fprc_pkg::ST_SLOW] = slow_sel;
      status_word[fprc_pkg::ST_PROT] = prot_state_r;
      status_word[fprc_pkg::ST_BUSRST] = bus_reset_r;
      count_word = '0;
      count_word[CNT_W-1:0] = panel_cnt_r;
   end

   // Unmapped addresses ack with zero and ignore writes
   assign rd_mux = hit_ctrl ? ctrl_word :
                   hit_status ? status_word :
                   hit_count ? count_word : 32'h0000_0000;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_r <= 1'b0;
         rd_data_r <= '0;
         fetch_gate_r <= fprc_pkg::CTRL_FETCH_GATE_RST;
      end else begin
         ack_r <= wb_req;
         rd_data_r <= wb_req ? rd_mux : rd_data_r;
         fetch_gate_r <= fetch_gate_nxt; // [R11]
      end
   end

   assign wb_ack_o = ack_r;
   assign wb_dat_o = rd_data_r;

   // Checks
   chk_ready_hold: assert property (@(posedge clk_i) disable iff (rst_i) // [R01]
      (stop_step_flipflop_r && !step_r) |-> !panel_ready_line_o)
      else $error("Ready high while halted");

   chk_stop_stages: assert property (@(posedge clk_i) disable iff (rst_i) // [R02]
      $rose(stop_stage2_r) |-> $past(stop_stage1_r) && $past(sync_clock_tap))
      else $error("Stop skipped a latch stage");

   chk_stop_boundary: assert property (@(posedge clk_i) disable iff (rst_i) // [R03]
      $rose(stop_step_flipflop_r) |-> $past(coincide_full) && $past(stop_stage2_r))
      else $error("Stop set off a fetch boundary");

   chk_stop_holds: assert property (@(posedge clk_i) disable iff (rst_i) // [R05]
      (stop_step_flipflop_r && !run_req) |=> stop_step_flipflop_r)
      else $error("Stop flop dropped without run");

   chk_protect_gated: assert property (@(posedge clk_i) disable iff (rst_i) // [R06]
      $rose(protect_o) || $rose(unprotect_o) |-> $past(stop_step_flipflop_r))
      else $error("Protect line driven while running");

   chk_run_indication: assert property (@(posedge clk_i) disable iff (rst_i) // [R07]
      stop_step_flipflop_r |-> !run_ind_o && (panel_ready_line_o == step_r))
      else $error("Run indication wrong while stopped");

   chk_step_ready: assert property (@(posedge clk_i) disable iff (rst_i) // [R08]
      (stop_step_flipflop_r && step_edge) |=> step_r && panel_ready_line_o)
      else $error("Step press did not raise ready");

   chk_step_clear: assert property (@(posedge clk_i) disable iff (rst_i) // [R09]
      (step_r && coincide_full && !step_set) |=> !step_r ##0 !panel_ready_line_o)
      else $error("Step not ended at boundary");

   chk_no_repeat: assert property (@(posedge clk_i) disable iff (rst_i) // [R10]
      (step_req && $past(step_req) && !slow_start && !step_r) |=> !step_r)
      else $error("Held step repeated");

   chk_fetch_option: assert property (@(posedge clk_i) disable iff (rst_i) // [R11]
      (!fetch_gate_r && cycle_mark && step_r && !step_set) |=> !step_r)
      else $error("Machine-cycle step not ended");

   chk_slow_start: assert property (@(posedge clk_i) disable iff (rst_i) // [R13]
      (stop_step_flipflop_r && slow_sel && slow_clock_tap) |=> step_r)
      else $error("Slow tick did not start a cycle");

   chk_reset_follow: assert property (@(posedge clk_i) disable iff (rst_i) // [R15]
      reset_req |=> bus_reset_o)
      else $error("Bus reset not driven");

   chk_lines_exclusive: assert property (@(posedge clk_i) disable iff (rst_i) // [R17]
      !(protect_o && unprotect_o))
      else $error("Protect and unprotect together");

   chk_slow_paced: assert property (@(posedge clk_i) disable iff (rst_i) // [R12]
      slow_clock_tap |-> $past(div_wrap))
      else $error("Slow tick off the divider");

   chk_slow_halt: assert property (@(posedge clk_i) disable iff (rst_i) // [R14]
      (!slow_sel && !step_edge && !step_r) |=> !step_r)
      else $error("Cycle started with slow off");

   chk_prot_latch: assert property (@(posedge clk_i) disable iff (rst_i) // [R16]
      prot_drive |=> prot_state_r)
      else $error("Protect state not set");

   chk_unprot_latch: assert property (@(posedge clk_i) disable iff (rst_i) // [R16]
      unprot_drive |=> !prot_state_r)
      else $error("Protect state not cleared");

   chk_run_synced: assert property (@(posedge clk_i) disable iff (rst_i) // [R18]
      $fell(stop_step_flipflop_r) |-> $past(run_req))
      else $error("Stop cleared without synced run");
endmodule
`default_nettype wire

// [test/fprc_cpu_model.sv]
`timescale 1ns/1ps
`default_nettype none
module fprc_cpu_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ready_i,
   input wire logic bus_reset_i,
   input wire logic protect_i,
   input wire logic unprotect_i,
   output logic sync_o,
   output logic strobe_o,
   output logic fetch_o,
   output logic mem_prot_o
);
   logic [1:0] ph_r;
   logic [1:0] mc_r;
   logic tog_r;
   wire logic mc_go;
   assign mc_go = ready_i & (ph_r == 2'h3);
   assign sync_o = mc_go;
   assign strobe_o = mc_go;
   // Toggles outside strobe so a stale level never reads as a fetch
   assign fetch_o = mc_go ? (mc_r == 2'h0) : tog_r;
   always_ff @(posedge clk_i) begin
      tog_r <= rst_i ? 1'b0 : ~tog_r;
      if (rst_i | bus_reset_i) begin
         ph_r <= 2'h0;
         mc_r <= 2'h0;
      end else if (ready_i) begin
         ph_r <= ph_r + 2'h1;
         if (mc_go) mc_r <= (mc_r == 2'h2) ? 2'h0 : mc_r + 2'h1;
      end
      if (rst_i) mem_prot_o <= 1'b0;
      else if (protect_i) mem_prot_o <= 1'b1;
      else if (unprotect_i) mem_prot_o <= 1'b0;
   end
endmodule
`default_nettype wire

// [test/front_panel_run_control_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module front_panel_run_control_bench;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'h0;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat;
   logic [6:0] sw = 7'h00;
   logic last_co = 1'b0;
   wire logic [31:0] dat_o;
   wire logic ack, rdy, run_ind, sw_en, bus_rst, prot, unprot, sync, strobe, fetch, mem_prot;
   int n_fail = 0;
   int n_tests = 0;
   int n_mc = 0;
   int n_ins = 0;
   always #10 clk_i = ~clk_i;
   // Small taps keep slow pacing within a short run
   fprc_run_control #(.SLOW_CYCLES(64), .CNT_W(24), .SYNC_TAP(1), .SLOW_TAP(3)) dut (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .sw_stop_i(sw[fprc_pkg::SW_STOP]), .sw_run_i(sw[fprc_pkg::SW_RUN]), .sw_step_i(sw[fprc_pkg::SW_STEP]),
      .sw_slow_i(sw[fprc_pkg::SW_SLOW]), .sw_reset_i(sw[fprc_pkg::SW_RESET]),
      .sw_protect_i(sw[fprc_pkg::SW_PROT]), .sw_unprotect_i(sw[fprc_pkg::SW_UNPROT]),
      .bus_cycle_sync_i(sync), .status_strobe_i(strobe), .fetch_status_bit_i(fetch),
      .panel_ready_line_o(rdy), .run_ind_o(run_ind), .switches_enable_o(sw_en), .bus_reset_o(bus_rst),
      .protect_o(prot), .unprotect_o(unprot));
   fprc_cpu_model cpu (.clk_i(clk_i), .rst_i(rst_i), .ready_i(rdy), .bus_reset_i(bus_rst), .protect_i(prot),
      .unprotect_i(unprot), .sync_o(sync), .strobe_o(strobe), .fetch_o(fetch), .mem_prot_o(mem_prot));
   always @(posedge clk_i) begin
      if (sync & strobe) begin
         n_mc <= n_mc + 1;
         if (fetch) n_ins <= n_ins + 1;
      end
   end
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic report_and_stop;
      $display("Checks %0d, mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
      int i;
      @(posedge clk_i);
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      sel <= s;
      wdat <= d;
      i = 0;
      do begin
         @(posedge clk_i);
         i++;
      end while (ack !== 1'b1 && i < 50);
      chk("wb ack", ack, 1);
      if (ack !== 1'b1) report_and_stop();
      rdat = dat_o;
      cyc <= 1'b0;
      we <= 1'b0;
   endtask
   task automatic press(input int b, input int n);
      sw[b] <= 1'b1;
      repeat (n) @(posedge clk_i);
      sw[b] <= 1'b0;
   endtask
   task automatic wait_rdy(input logic v);
      int i;
      for (i = 0; i < 3000; i++) begin
         @(posedge clk_i);
         if (rdy === v) break;
         last_co = sync & strobe & fetch;
      end
      chk("ready wait", rdy, v);
      if (rdy !== v) report_and_stop();
   endtask
   task automatic t_reset;
      logic [31:0] c;
      chk("ready", rdy, 1);
      chk("run", run_ind, 1);
      chk("sw_en", sw_en, 0);
      wb(0, fprc_pkg::REG_STATUS, 4'hf, 0);
      chk("status", rdat, 32'h4);
      wb(1, fprc_pkg::REG_CTRL, 4'h0, 0);
      wb(0, fprc_pkg::REG_CTRL, 4'hf, 0);
      chk("ctrl", rdat, 32'h1);
      wb(0, 8'h0c, 4'hf, 0);
      chk("unmapped", rdat, 32'h0);
      wb(0, fprc_pkg::REG_COUNT, 4'hf, 0);
      c = rdat;
      // Reads spaced wider than one counter step
      repeat (4) @(posedge clk_i);
      wb(0, fprc_pkg::REG_COUNT, 4'hf, 0);
      chk("count runs", rdat != c, 1);
      chk("count width", rdat[31:24], 0);
   endtask
   task automatic t_stop;
      int m;
      fork
         press(fprc_pkg::SW_STOP, 40);
         wait_rdy(0);
      join
      chk("stop at fetch", last_co, 1);
      chk("run", run_ind, 0);
      chk("sw_en", sw_en, 1);
      m = n_mc;
      repeat (60) @(posedge clk_i);
      chk("held stop", rdy, 0);
      chk("halted", n_mc, m);
   endtask
   task automatic t_step(input logic g, input int exp_mc, input int exp_ins);
      int m;
      int f;
      wb(1, fprc_pkg::REG_CTRL, 4'h1, {31'h0, g});
      m = n_mc;
      f = n_ins;
      // Step held long: one step only, a single machine cycle when the fetch gate is clear
      fork
         press(fprc_pkg::SW_STEP, 200);
         begin
            wait_rdy(1);
            wait_rdy(0);
         end
      join
      chk("step cycles", n_mc - m, exp_mc);
      chk("step fetches", n_ins - f, exp_ins);
      chk("step ends", rdy, 0);
   endtask
   task automatic t_slow;
      int m;
      m = n_ins;
      sw[fprc_pkg::SW_SLOW] <= 1'b1;
      // Long enough for three finished ticks at any counter phase
      repeat (260) @(posedge clk_i);
      chk("slow runs", (n_ins - m) >= 3, 1);
      chk("slow pace", (n_ins - m) <= 8, 1);
      sw[fprc_pkg::SW_SLOW] <= 1'b0;
      repeat (60) @(posedge clk_i);
      m = n_mc;
      repeat (100) @(posedge clk_i);
      chk("slow off halts", n_mc, m);
   endtask
   task automatic t_prot(input int b, input logic p);
      sw[b] <= 1'b1;
      repeat (6) @(posedge clk_i);
      chk("protect", prot, p);
      chk("unprotect", unprot, !p);
      chk("memory", mem_prot, p);
      sw[b] <= 1'b0;
      repeat (6) @(posedge clk_i);
      wb(0, fprc_pkg::REG_STATUS, 4'hf, 0);
      chk("status", rdat, {27'h0, p, 4'h1});
   endtask
   task automatic t_run_reset;
      sw[fprc_pkg::SW_RUN] <= 1'b1;
      wait_rdy(1);
      sw[fprc_pkg::SW_RUN] <= 1'b0;
      sw[fprc_pkg::SW_PROT] <= 1'b1;
      repeat (6) @(posedge clk_i);
      chk("protect running", prot, 0);
      sw[fprc_pkg::SW_PROT] <= 1'b0;
      sw[fprc_pkg::SW_RESET] <= 1'b1;
      repeat (5) @(posedge clk_i);
      chk("bus reset", bus_rst, 1);
      wb(0, fprc_pkg::REG_STATUS, 4'hf, 0);
      chk("status", rdat, 32'h24);
      sw[fprc_pkg::SW_RESET] <= 1'b0;
      repeat (5) @(posedge clk_i);
      chk("bus reset off", bus_rst, 0);
   endtask
   initial begin
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_stop();
      t_step(1, 3, 1);
      t_step(0, 1, 0);
      t_step(1, 2, 1);
      t_slow();
      t_prot(fprc_pkg::SW_PROT, 1);
      t_prot(fprc_pkg::SW_UNPROT, 0);
      t_run_reset();
      report_and_stop();
   end
endmodule
`default_nettype wire
